// ==== hw/coil_cmd_decoder.sv ====
// Functional notes
// [R01] Frames are delimited by bus silence; the gap strobe closes a frame.
// [R02] Slave address is axis number plus one; 00 is broadcast.
// [R03] Only function 05 with coil address and value, eight bytes total.
// [R04] Frame CRC checked before any action is taken.
// [R05] Coil 0414: FF00 enters teaching mode, 0000 returns to normal.
// [R06] Coil 0415 FF00 in teaching mode captures current position.
// [R07] Capture goes to entry named by position number register then.
// [R08] Load also asks storage to fill empty fields with defaults.
// [R09] Master holds the capture coil unchanged 20 ms after FF00.
// [R10] Jog mode: FF00 on 0416 jogs away from home.
// [R11] While jogging, 0000 on positive or FF00 on negative stops.
// [R12] Inch mode: rising edge on positive coil starts one inch.
// [R13] Master writes 0000 between inch requests to re-arm the edge.
// [R14] Successful write answered with an exact echo of the query.
// [R15] Coil 0411 picks inch or jog; change stops jog, inch completes.
// [R16] Coil 0417 is the mirrored jog/inch toward home.
// [R17] Broadcast frames are executed but never answered.
`timescale 1ns/1ps
`default_nettype none
`include "coil_params.svh"

module coil_cmd_decoder
  import coil_pkg::*;
(
  input wire logic mclk, // Controller clock, 40 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic [3:0] axis_id, // Axis number of this controller
  input wire logic rx_valid, // Received byte strobe
  input wire logic [7:0] rx_byte, // Received byte
  input wire logic frame_gap, // Silent interval seen, one pulse
  input wire logic tx_ready, // Transmitter takes tx_byte
  input wire logic [`POS_W-1:0] current_position, // Actuator position
  input wire logic [`PNUM_W-1:0] position_number_cmd_reg, // Selected entry
  output logic tx_valid, // Response byte offered
  output logic [7:0] tx_byte, // Response byte
  output logic teach_mode_select, // High in teaching mode
  output logic position_capture_cmd, // Capture coil state
  output logic jog_inch_select, // High selects inching
  output logic load_strobe, // One pulse: write table entry
  output logic [`PNUM_W-1:0] load_entry, // Entry to write
  output logic [`POS_W-1:0] load_target, // Captured target position
  output logic load_fill_defaults, // Fill empty fields with defaults
  output logic jog_run, // Continuous jog in progress
  output logic move_dir, // 1 away from home, 0 toward
  output logic inch_start, // One pulse: start one inch
  output logic stop_req, // One pulse: decelerate to stop
  output logic frame_done // One pulse: frame accepted and run
);

  dec_regs_t q;
  dec_regs_t next_q;
  crc_if cif ();

  // ----------------------------------------------------------------
  // CRC over every byte of the frame, including the CRC itself
  // ----------------------------------------------------------------
  crc16_unit u_crc (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cif(cif)
  );

  // Remainder restarts on every gap so the next frame starts clean
  assign cif.clr = frame_gap; // [R01]
  assign cif.en = (q.st == ST_RX) && rx_valid && !frame_gap;
  assign cif.data = rx_byte;

  // ----------------------------------------------------------------
  // Frame decode and coil handling
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] addr;
    logic [15:0] coil;
    logic [15:0] val;
    logic on;
    logic good;
    logic away;
    logic prev;
    logic is_jog;
    logic len_ok;
    logic crc_ok;
    logic addr_ok;
    logic cmd_ok;
    // Fields are read from the stored frame, high byte first
    addr = q.frame[`IDX_ADDR];
    coil = {q.frame[`IDX_COIL_HI], q.frame[`IDX_COIL_LO]};
    val = {q.frame[`IDX_VAL_HI], q.frame[`IDX_VAL_LO]};
    on = (val == `VAL_ON);
    away = (coil == `COIL_JOG_POS);
    prev = away ? q.jp_coil : q.jn_coil;
    is_jog = (coil == `COIL_JOG_POS) || (coil == `COIL_JOG_NEG);
    // Each test stands alone so a refused frame is easy to trace
    len_ok = (q.cnt == `FRAME_LEN) && !q.ovf; // [R03]
    crc_ok = (cif.crc == `CRC_GOOD); // [R04]
    addr_ok = (addr == {3'h0, 5'({1'b0, axis_id} + 5'h01)}) // [R02]
      || (addr == `ADDR_BCAST);
    // Anything but the five coils and the two values gets no answer
    cmd_ok = (q.frame[`IDX_FUNC] == `FC_WRITE_COIL) // [R03]
      && ((val == `VAL_ON) || (val == `VAL_OFF))
      && (is_jog || (coil == `COIL_TEACH) || (coil == `COIL_CAPTURE)
        || (coil == `COIL_JOG_INCH));
    good = len_ok && crc_ok && addr_ok && cmd_ok;
    next_q = q;
    // Pulses last one clock unless this frame raises them again
    next_q.inch_start = 1'b0;
    next_q.stop_req = 1'b0;
    next_q.load_stb = 1'b0;
    next_q.done = 1'b0;
    unique case (q.st)
      ST_RX: begin
        // Bytes are gathered until silence; extra bytes spoil the frame
        if (frame_gap) begin
          next_q.cnt = 4'h0;
          next_q.ovf = 1'b0;
          if (good) begin
            next_q.done = 1'b1;
            if (coil == `COIL_TEACH) begin
              next_q.teach = on; // [R05]
            end
            if (coil == `COIL_CAPTURE) begin
              next_q.cap_coil = on;
              // Outside teaching mode only the coil level follows
              if (on && q.teach) begin
                next_q.load_stb = 1'b1; // [R06]
                next_q.load_entry = position_number_cmd_reg; // [R07]
                next_q.load_target = current_position; // [R07]
              end
            end
            if (coil == `COIL_JOG_INCH) begin
              next_q.sel_inch = on;
              // A running jog stops on a mode change; an inch runs on
              if (q.jog_run && (on != q.sel_inch)) begin
                next_q.jog_run = 1'b0; // [R15]
                next_q.stop_req = 1'b1; // [R15]
              end
            end
            if (is_jog) begin
              if (away) begin
                next_q.jp_coil = on;
              end else begin
                next_q.jn_coil = on;
              end
              // FF00 on the running direction is ignored; jog goes on
              if (q.jog_run && (!on || (away != q.move_dir))) begin
                next_q.jog_run = 1'b0; // [R11]
                next_q.stop_req = 1'b1; // [R11]
              end else if (on && !q.sel_inch && !q.jog_run) begin
                next_q.jog_run = 1'b1; // [R10] [R16]
                next_q.move_dir = away; // [R10] [R16]
              end else if (on && q.sel_inch && !prev) begin
                // Edge needs the coil back at 0000 first
                next_q.inch_start = 1'b1; // [R12] [R13] [R16]
                next_q.move_dir = away; // [R12] [R16]
              end
            end
            // Broadcast is acted on but stays silent on the bus
            if (addr != `ADDR_BCAST) begin // [R17]
              next_q.st = ST_TX;
              next_q.txi = 3'h0;
              next_q.tx_valid = 1'b1;
              next_q.tx_byte = q.frame[0]; // [R14]
            end
          end
        end else if (rx_valid) begin
          if (q.cnt == `FRAME_LEN) begin
            next_q.ovf = 1'b1;
          end else begin
            next_q.frame[q.cnt[2:0]] = rx_byte;
            next_q.cnt = q.cnt + 4'h1;
          end
        end
      end
      ST_TX: begin
        // Echo all eight bytes, CRC included, untouched
        if (tx_ready) begin
          // Last byte hands the line back; a query may follow at once
          if (q.txi == `FRAME_LAST) begin
            next_q.st = ST_RX;
            next_q.tx_valid = 1'b0;
          end else begin
            next_q.txi = q.txi + 3'h1;
            next_q.tx_byte = q.frame[q.txi + 3'h1]; // [R14]
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign tx_valid = q.tx_valid;
  assign tx_byte = q.tx_byte;
  assign teach_mode_select = q.teach;
  assign position_capture_cmd = q.cap_coil;
  assign jog_inch_select = q.sel_inch;
  assign load_strobe = q.load_stb;
  assign load_entry = q.load_entry;
  assign load_target = q.load_target;
  // Asserted with each load; storage keeps fields that hold data
  assign load_fill_defaults = q.load_stb; // [R08]
  assign jog_run = q.jog_run;
  assign move_dir = q.move_dir;
  assign inch_start = q.inch_start;
  assign stop_req = q.stop_req;
  assign frame_done = q.done;

endmodule

`default_nettype wire

// ==== hw/coil_params.svh ====
`ifndef COIL_PARAMS_SVH
`define COIL_PARAMS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define FRAME_LEN 4'h8
`define FRAME_LAST 3'h7
`define IDX_ADDR 3'h0
`define IDX_FUNC 3'h1
`define IDX_COIL_HI 3'h2
`define IDX_COIL_LO 3'h3
`define IDX_VAL_HI 3'h4
`define IDX_VAL_LO 3'h5
`define ADDR_BCAST 8'h00
`define FC_WRITE_COIL 8'h05

// ----------------------------------------------------------------
// Coil addresses and values
// ----------------------------------------------------------------
`define COIL_JOG_INCH 16'h0411
`define COIL_TEACH 16'h0414
`define COIL_CAPTURE 16'h0415
`define COIL_JOG_POS 16'h0416
`define COIL_JOG_NEG 16'h0417
`define VAL_ON 16'hFF00
`define VAL_OFF 16'h0000

// ----------------------------------------------------------------
// CRC and widths
// ----------------------------------------------------------------
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define CRC_GOOD 16'h0000
`define POS_W 32
`define PNUM_W 10

`endif

// ==== hw/coil_pkg.sv ====
`include "coil_params.svh"

package coil_pkg;

  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_TX = 2'b01
  } dec_state_t;

  typedef struct packed {
    dec_state_t st;
    logic [7:0][7:0] frame;
    logic [3:0] cnt;
    logic ovf;
    logic [2:0] txi;
    logic teach;
    logic cap_coil;
    logic sel_inch;
    logic jp_coil;
    logic jn_coil;
    logic jog_run;
    logic move_dir;
    logic inch_start;
    logic stop_req;
    logic load_stb;
    logic [`PNUM_W-1:0] load_entry;
    logic [`POS_W-1:0] load_target;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic done;
  } dec_regs_t;

  typedef struct packed {
    logic [15:0] crc;
  } crc_regs_t;

endpackage

// ==== hw/crc_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Byte stream into the CRC unit and running remainder back
interface crc_if;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport calc (input clr, input en, input data, output crc);
  modport user (output clr, output en, output data, input crc);
endinterface

`default_nettype wire

// ==== hw/crc16_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "coil_params.svh"

module crc16_unit
  import coil_pkg::*;
(
  input wire logic mclk, // Controller clock
  input wire logic sys_rst, // Async reset, active high
  crc_if.calc cif // Byte feed and remainder
);

  crc_regs_t q;
  crc_regs_t next_q;

  // ----------------------------------------------------------------
  // Reflected CRC-16, one byte per cycle
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] c;
    c = q.crc ^ {8'h00, cif.data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    next_q = q;
    // Clear wins so a new frame never inherits a stale remainder
    if (cif.clr) begin
      next_q.crc = `CRC_INIT;
    end else if (cif.en) begin
      next_q.crc = c;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{crc: `CRC_INIT};
    end else begin
      q <= next_q;
    end
  end

  assign cif.crc = q.crc;

endmodule

`default_nettype wire

// ==== tb/coil_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "coil_params.svh"
module coil_checker(
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [3:0] axis_id, // Axis
  input wire logic frame_gap, // Silence
  input wire logic tx_ready, // Taken
  input wire logic [`POS_W-1:0] current_position, // Position
  input wire logic [`PNUM_W-1:0] position_number_cmd_reg, // Entry
  input wire logic tx_valid, // Offered
  input wire logic [7:0] tx_byte, // Reply
  input wire logic teach_mode_select, // Mode
  input wire logic load_strobe, // Load
  input wire logic [`PNUM_W-1:0] load_entry, // Entry
  input wire logic [`POS_W-1:0] load_target, // Target
  input wire logic load_fill_defaults, // Fill
  input wire logic jog_run, // Jog
  input wire logic inch_start, // Inch
  input wire logic stop_req, // Stop
  input wire logic frame_done // Done
);
  // ----------------------------------------
  // Port relations, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_fill_pair: assert property (
    load_fill_defaults == load_strobe) else $error("fill differs");
  a_load_teach: assert property (
    load_strobe |-> teach_mode_select && frame_done) else $error("load");
  a_load_pos: assert property (
    load_strobe |-> load_target == $past(current_position))
    else $error("target");
  a_load_entry: assert property (
    load_strobe |-> load_entry == $past(position_number_cmd_reg))
    else $error("entry");
  a_inch_pulse: assert property (
    inch_start |=> !inch_start) else $error("inch pulse");
  a_stop_clear: assert property (
    stop_req |-> !jog_run && frame_done) else $error("stop");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply not held");
  a_done_gap: assert property (
    frame_done |-> $past(frame_gap)) else $error("done w/o gap");
  a_first_addr: assert property (
    $rose(tx_valid) |-> tx_byte == {4'h0, axis_id} + 8'h01)
    else $error("reply address");
  a_teach_cmd: assert property (
    $changed(teach_mode_select) |-> frame_done) else $error("mode");
endmodule
bind coil_cmd_decoder coil_checker u_chk (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .axis_id(axis_id),
  .frame_gap(frame_gap),
  .tx_ready(tx_ready),
  .current_position(current_position),
  .position_number_cmd_reg(position_number_cmd_reg),
  .tx_valid(tx_valid),
  .tx_byte(tx_byte),
  .teach_mode_select(teach_mode_select),
  .load_strobe(load_strobe),
  .load_entry(load_entry),
  .load_target(load_target),
  .load_fill_defaults(load_fill_defaults),
  .jog_run(jog_run),
  .inch_start(inch_start),
  .stop_req(stop_req),
  .frame_done(frame_done)
);
`default_nettype wire

// ==== tb/bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "coil_params.svh"
module bus_master #(
  parameter int CAP_HOLD = 200 // Capture hold in clocks, scaled down
) (
  input wire logic mclk, // Clock
  input wire logic tx_valid, // Reply offered
  input wire logic [7:0] tx_byte, // Reply byte
  output logic rx_valid, // Byte strobe
  output logic [7:0] rx_byte, // Byte
  output logic frame_gap, // Silence pulse
  output logic tx_ready // Reply taken
);
  // ----------------------------------------
  // Serial master: queries out, echo in
  // ----------------------------------------
  logic [7:0] f [8];
  logic [7:0] r [8];
  int n;
  bit cap_on; // Capture coil last written FF00
  initial begin
    rx_valid = 0;
    rx_byte = 8'h00;
    frame_gap = 0;
    tx_ready = 0;
  end
  // Eight-byte query, CRC low byte first; bad spoils the CRC
  task automatic send(input logic [7:0] a, input logic [15:0] c, v,
    input bit bad);
    logic [15:0] crc;
    // Capture coil left alone after FF00; 20 ms shrunk for run length
    if (c == `COIL_CAPTURE && cap_on) begin
      repeat (CAP_HOLD) @(posedge mclk);
    end
    if (c == `COIL_CAPTURE) begin
      cap_on = (v == `VAL_ON);
    end
    crc = `CRC_INIT;
    f = '{a, `FC_WRITE_COIL, c[15:8], c[7:0], v[15:8], v[7:0],
      8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      crc ^= {8'h00, f[i]};
      repeat (8) crc = crc[0] ? (crc >> 1) ^ `CRC_POLY : crc >> 1;
    end
    f[6] = crc[7:0] ^ {7'h00, bad};
    f[7] = crc[15:8];
    n = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk) #1;
      rx_valid = 1;
      rx_byte = f[i];
    end
    // Line released: data shows junk in the same cycle as the silence pulse
    @(posedge mclk) #1;
    rx_valid = 0;
    rx_byte = ~f[7];
    frame_gap = 1;
    @(posedge mclk) #1;
    frame_gap = 0;
    // Ready on every other edge so the reply must wait; the byte is
    // taken while it stands and ready drops after the edge takes it
    repeat (30) begin
      @(posedge mclk) #1;
      tx_ready = !tx_ready && tx_valid && (n < 8);
      if (tx_ready) begin
        r[n] = tx_byte;
        n++;
      end
    end
    @(posedge mclk) #1;
    tx_ready = 0;
  endtask
endmodule
`default_nettype wire

// ==== tb/coil_cmd_decoder_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "coil_params.svh"
module coil_cmd_decoder_tb import coil_pkg::*;;
  // ----------------------------------------
  // Bench: axis 2 answers address 03
  // ----------------------------------------
  localparam logic [7:0] ADR = 8'h03;
  logic mclk, sys_rst, rx_valid, frame_gap, tx_ready, tx_valid;
  logic [7:0] rx_byte, tx_byte;
  logic [`POS_W-1:0] pos, ltgt;
  logic [`PNUM_W-1:0] pnum, lent;
  logic teach, capc, jis, lds, jog, dir, inch, stop, done;
  int n_fail, checks_done, n_inch, n_stop, n_load, n_done, cyc;
  always #12.5 mclk = ~mclk;
  coil_cmd_decoder DUT(.mclk(mclk), .sys_rst(sys_rst),
    .axis_id(4'h2), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .frame_gap(frame_gap), .tx_ready(tx_ready),
    .current_position(pos), .position_number_cmd_reg(pnum),
    .tx_valid(tx_valid), .tx_byte(tx_byte),
    .teach_mode_select(teach), .position_capture_cmd(capc),
    .jog_inch_select(jis), .load_strobe(lds), .load_entry(lent),
    .load_target(ltgt), .load_fill_defaults(), .jog_run(jog),
    .move_dir(dir), .inch_start(inch), .stop_req(stop),
    .frame_done(done));
  bus_master u_m(.mclk(mclk), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .frame_gap(frame_gap),
    .tx_ready(tx_ready));
  // Pulse tallies at the falling edge, where each pulse stands settled
  always @(negedge mclk) begin
    n_inch += inch;
    n_stop += stop;
    n_load += lds;
    n_done += done;
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Query, then judge the echo byte by byte
  task automatic x(input logic [7:0] a, input logic [15:0] c, v,
    input bit bad, input int en);
    u_m.send(a, c, v, bad);
    check(u_m.n, en);
    for (int i = 0; i < en; i++) check(u_m.r[i], u_m.f[i]);
  endtask
  task automatic w(input logic [15:0] c, v);
    x(ADR, c, v, 0, 8);
  endtask
  task automatic t_refuse();
    x(ADR, `COIL_TEACH, `VAL_ON, 1, 0);
    x(8'h04, `COIL_TEACH, `VAL_ON, 0, 0);
    x(ADR, 16'h0412, `VAL_ON, 0, 0);
    x(ADR, `COIL_TEACH, 16'h1234, 0, 0);
    check(teach, 0);
    check(n_done, 0);
    x(`ADDR_BCAST, `COIL_TEACH, `VAL_ON, 0, 0);
    check(teach, 1);
    check(n_done, 1);
    w(`COIL_TEACH, `VAL_OFF);
    check(teach, 0);
    $display("t_refuse over");
  endtask
  // Hold time after capture is shortened; the block does not time it
  task automatic t_teach();
    pos = 32'hA5C3_0F12;
    pnum = 10'h2A7;
    w(`COIL_CAPTURE, `VAL_ON);
    check(capc, 1);
    check(n_load, 0);
    w(`COIL_TEACH, `VAL_ON);
    w(`COIL_CAPTURE, `VAL_ON);
    check(n_load, 1);
    check(ltgt, 32'hA5C3_0F12);
    check(lent, 10'h2A7);
    $display("t_teach over");
  endtask
  task automatic t_jog();
    w(`COIL_JOG_INCH, `VAL_OFF);
    w(`COIL_JOG_POS, `VAL_ON);
    check({jog, dir}, 2'b11);
    w(`COIL_JOG_NEG, `VAL_ON);
    check({jog, 8'(n_stop)}, 9'h001);
    w(`COIL_JOG_NEG, `VAL_ON);
    check({jog, dir}, 2'b10);
    w(`COIL_JOG_NEG, `VAL_OFF);
    check({jog, 8'(n_stop)}, 9'h002);
    w(`COIL_JOG_POS, `VAL_OFF);
    w(`COIL_JOG_POS, `VAL_ON);
    w(`COIL_JOG_INCH, `VAL_ON);
    check({jis, jog, 8'(n_stop)}, 10'h203);
    $display("t_jog over");
  endtask
  task automatic t_inch();
    w(`COIL_JOG_POS, `VAL_OFF);
    w(`COIL_JOG_POS, `VAL_ON);
    check({dir, 8'(n_inch)}, 9'h101);
    w(`COIL_JOG_POS, `VAL_ON);
    check(n_inch, 1);
    w(`COIL_JOG_POS, `VAL_OFF);
    w(`COIL_JOG_POS, `VAL_ON);
    check(n_inch, 2);
    w(`COIL_JOG_NEG, `VAL_ON);
    check({dir, 8'(n_inch)}, 9'h003);
    $display("t_inch over");
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    mclk = 0;
    sys_rst = 1;
    pos = 0;
    pnum = 0;
    repeat (8) @(posedge mclk);
    #1 sys_rst = 0;
    t_refuse();
    t_teach();
    t_jog();
    t_inch();
    complete_run();
  end
endmodule
`default_nettype wire
